// File: logic/fim_pkg.sv
// Package for the identification-read mode block.
// Assumes a 16-bit word-addressed flash bus with sixteen banks.
package fim_pkg;
    localparam int ADDR_W      = 25;
    localparam int DATA_W      = 16;
    localparam int BANK_W      = 4;
    localparam int SECT_W      = 9;
    localparam int OFS_W       = 12;
    // Command sequence
    localparam logic [11:0] UNLOCK1_OFS = 12'h555;
    localparam logic [11:0] UNLOCK2_OFS = 12'h2aa;
    localparam logic [7:0]  UNLOCK1_DAT = 8'haa;
    localparam logic [7:0]  UNLOCK2_DAT = 8'h55;
    localparam logic [7:0]  IDENT_CMD   = 8'h90;
    localparam logic [7:0]  RESET_CMD   = 8'hf0;
    // Identification word offsets
    localparam logic [7:0] MAKER_OFS  = 8'h00;
    localparam logic [7:0] PART1_OFS  = 8'h01;
    localparam logic [7:0] LOCK_OFS   = 8'h02;
    localparam logic [7:0] INDIC_OFS  = 8'h07;
    localparam logic [7:0] PART2_OFS  = 8'h0e;
    localparam logic [7:0] PART3_OFS  = 8'h0f;
    // Indicator field positions
    localparam int FACTORY_LOCK_BIT  = 7;
    localparam int CUSTOMER_LOCK_BIT = 6;
    localparam int HANDSHAKE_BIT     = 5;
    localparam int WP_CODE_LSB       = 3;
    localparam logic [1:0] WP_TOP_BOOT = 2'h1;
    // Identity values, arbitrary
    localparam logic [15:0] MAKER_CODE = 16'h00a5;
    localparam logic [15:0] PART_CODE1 = 16'h1234;
    localparam logic [15:0] PART_CODE2 = 16'h5678;
    localparam logic [15:0] PART_CODE3 = 16'h9abc;
    localparam logic [15:0] ZERO_WORD  = 16'h0000;

    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'b00,
        SEQ_GOT1  = 2'b01,
        SEQ_GOT2  = 2'b10
    } fim_seq_t;
endpackage

// File: logic/fim_bank.sv
// One bank's mode tracker: read, erase-suspended read, identification.
// Assumes writes are one-cycle strobes; entry is decoded for this bank, exit is shared by all banks.
`timescale 1ns/1ns
module fim_bank
    import fim_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk_in,
    input  wire logic rst_n_in,
    // Events
    input  wire logic enter_in,
    input  wire logic exit_in,
    input  wire logic suspend_in,
    // Status
    output logic      ident_out,
    output logic      susp_out
);
    typedef struct packed {
        logic ident;
        logic susp;
    } fim_bank_st_t;

    fim_bank_st_t s_q, s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.susp = suspend_in;
        if (enter_in)
            s_d.ident = 1'b1;
        // Exit clears ident only; susp follows suspend_in, so the read mode is the current one
        else if (exit_in)
            s_d.ident = 1'b0;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign ident_out = s_q.ident;
    assign susp_out  = s_q.susp;
endmodule

// File: logic/fim_top.sv
// Identification-read mode of a sixteen-bank parallel flash.
// Assumes single-cycle synchronous write and read strobes from the host
// and a backing array that supplies normal read data.
`timescale 1ns/1ns
module fim_top
    import fim_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk_in,
    input  wire logic              rst_n_in,
    // Host bus
    input  wire logic              wr_in,
    input  wire logic              rd_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] wdata_in,
    output logic      [DATA_W-1:0] rdata_out,
    output logic                   rvalid_out,
    // Array side
    input  wire logic [DATA_W-1:0] array_data_in,
    input  wire logic              busy_in,
    input  wire logic [15:0]       suspended_in,
    input  wire logic [511:0]      sector_lock_in,
    input  wire logic              factory_lock_flag_in,
    input  wire logic              customer_lock_flag_in,
    // Status
    output logic      [15:0]       ident_banks_out
);
    typedef struct packed {
        fim_seq_t          seq;
        logic [BANK_W-1:0] seq_bank;
        logic [DATA_W-1:0] rdata;
        logic              rvalid;
        logic [15:0]       idb;
    } fim_top_st_t;

    fim_top_st_t s_q, s_d;

    logic [BANK_W-1:0] bank_sel;
    logic [OFS_W-1:0]  ofs_lo;
    logic [SECT_W-1:0] sect_sel;
    logic [7:0]        wbyte;
    logic              enter;
    logic              exit_cmd;
    logic [15:0]       ident_b;
    logic [DATA_W-1:0] ident_word;

    assign bank_sel = addr_in[ADDR_W-1 -: BANK_W];
    assign sect_sel = addr_in[ADDR_W-1 -: SECT_W];
    assign ofs_lo   = addr_in[OFS_W-1:0];
    assign wbyte    = wdata_in[7:0];
    // Exit takes F0 at any address of the device
    assign exit_cmd = wr_in && (wbyte == RESET_CMD);

    ////////////////////////////////////////////////////////////////////////
    // Entry sequence

    always_comb
    begin
        enter = 1'b0;
        if (wr_in && s_q.seq == SEQ_GOT2 && ofs_lo == UNLOCK1_OFS
            && wbyte == IDENT_CMD && bank_sel == s_q.seq_bank
            && !busy_in && !ident_b[bank_sel])
            enter = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-bank mode

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++)
        begin : g_bank
            fim_bank u_bank (
                .core_clk_in (core_clk_in),
                .rst_n_in    (rst_n_in),
                .enter_in    (enter && bank_sel == BANK_W'(gi)),
                .exit_in     (exit_cmd),
                .suspend_in  (suspended_in[gi]),
                .ident_out   (ident_b[gi]),
                // Suspend level is tracked outside; not needed here
                .susp_out    ()
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Identification word select

    always_comb
    begin
        ident_word = ZERO_WORD;
        case (ofs_lo[7:0])
            MAKER_OFS: ident_word = MAKER_CODE;
            PART1_OFS: ident_word = PART_CODE1;
            PART2_OFS: ident_word = PART_CODE2;
            PART3_OFS: ident_word = PART_CODE3;
            // Only sector bits and offset matter for the lock query
            LOCK_OFS:  ident_word = {15'h0000,
                                     sector_lock_in[sect_sel]};
            INDIC_OFS:
            begin
                ident_word[FACTORY_LOCK_BIT]  = factory_lock_flag_in;
                ident_word[CUSTOMER_LOCK_BIT] = customer_lock_flag_in;
                ident_word[HANDSHAKE_BIT]     = 1'b0;
                ident_word[WP_CODE_LSB +: 2]  = WP_TOP_BOOT;
            end
            default:   ident_word = ZERO_WORD;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer and read path

    always_comb
    begin
        s_d        = s_q;
        s_d.rvalid = rd_in;
        s_d.idb    = ident_b;
        // Single-word reads only; other banks see the array
        if (rd_in)
            s_d.rdata = ident_b[bank_sel] ? ident_word
                                          : array_data_in;
        if (wr_in)
        begin
            // Any mismatch drops back to idle, except AA at 555 in GOT1 which restarts at GOT1; bank mode untouched
            s_d.seq = SEQ_IDLE;
            case (s_q.seq)
                SEQ_IDLE:
                    if (ofs_lo == UNLOCK1_OFS && wbyte == UNLOCK1_DAT)
                    begin
                        s_d.seq      = SEQ_GOT1;
                        s_d.seq_bank = bank_sel;
                    end
                SEQ_GOT1:
                    if (ofs_lo == UNLOCK2_OFS && wbyte == UNLOCK2_DAT
                        && bank_sel == s_q.seq_bank)
                        s_d.seq = SEQ_GOT2;
                    else if (ofs_lo == UNLOCK1_OFS && wbyte == UNLOCK1_DAT)
                    begin
                        s_d.seq      = SEQ_GOT1;
                        s_d.seq_bank = bank_sel;
                    end
                SEQ_GOT2:
                    s_d.seq = SEQ_IDLE;
                default:
                    s_d.seq = SEQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            s_q.seq      <= SEQ_IDLE;
            s_q.seq_bank <= 4'h0;
            s_q.rdata    <= 16'h0000;
            s_q.rvalid   <= 1'b0;
            s_q.idb      <= 16'h0000;
        end
        else
            s_q <= s_d;
    end

    assign rdata_out       = s_q.rdata;
    assign rvalid_out      = s_q.rvalid;
    assign ident_banks_out = s_q.idb;
endmodule

// File: testbench/fim_monitor.sv
// Port checker for the identification-read block.
// One clock domain; bound to every fim_top instance.
`timescale 1ns/1ns
module fim_monitor
    import fim_pkg::*;
(
    // Observed ports
    input wire logic              core_clk_in,
    input wire logic              rst_n_in,
    input wire logic              wr_in,
    input wire logic              rd_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic [DATA_W-1:0] rdata_out,
    input wire logic              rvalid_out,
    input wire logic [DATA_W-1:0] array_data_in,
    input wire logic              busy_in,
    input wire logic [511:0]      sector_lock_in,
    input wire logic [15:0]       ident_banks_out
);
    logic [3:0]  bank;
    logic [7:0]  ofs;
    logic [7:0]  cmd;
    logic        hit;
    logic        cold;
    logic        lock_q;
    logic        wr_q;
    logic [15:0] prev_q;
    logic [15:0] rise;
    assign bank = addr_in[24:21];
    assign ofs = addr_in[7:0];
    assign cmd = wdata_in[7:0];
    // Status lags one cycle, so a read just after a write is not judged
    assign hit = rd_in && ident_banks_out[bank] && !wr_q;
    assign cold = rd_in && !ident_banks_out[bank] && !wr_q;
    assign rise = ident_banks_out & ~prev_q;
    always_ff @(posedge core_clk_in)
    begin
        lock_q <= sector_lock_in[addr_in[24:16]];
        wr_q <= wr_in;
        prev_q <= ident_banks_out;
    end
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    read_answer_a: assert property (rd_in |=> rvalid_out)
        else $error("read not answered");
    rdata_hold_a: assert property (!rd_in |=> $stable(rdata_out))
        else $error("rdata moved");
    exit_all_a: assert property (wr_in && cmd == RESET_CMD
        |-> ##2 ident_banks_out == 16'h0) else $error("exit ignored");
    entry_cause_a: assert property (rise != 16'h0
        |-> $past(wr_in, 2) && !$past(busy_in, 2)
        && $past(cmd, 2) == IDENT_CMD) else $error("stray entry");
    entry_bank_a: assert property (rise != 16'h0
        |-> rise == 16'h1 << $past(bank, 2)) else $error("wrong bank");
    lock_word_a: assert property (hit && ofs == LOCK_OFS
        |=> rdata_out == {15'h0, lock_q}) else $error("bad lock word");
    maker_word_a: assert property (hit && ofs == MAKER_OFS
        |=> rdata_out == MAKER_CODE) else $error("bad maker word");
    array_read_a: assert property (cold
        |=> rdata_out == $past(array_data_in)) else $error("bad array word");
endmodule
bind fim_top fim_monitor mon (.core_clk_in, .rst_n_in, .wr_in, .rd_in,
    .addr_in, .wdata_in, .rdata_out, .rvalid_out, .array_data_in, .busy_in,
    .sector_lock_in, .ident_banks_out);

// File: testbench/fim_host_model.sv
// Host controller model: one bus cycle per put call, five per entry call.
// Caller sits just after a rising edge; idle calls release strobes.
`timescale 1ns/1ns
module fim_host_model
    import fim_pkg::*;
(
    // Clock
    input  wire logic              core_clk_in,
    // Flash bus
    output logic                   wr_out,
    output logic                   rd_out,
    output logic      [ADDR_W-1:0] addr_out,
    output logic      [DATA_W-1:0] wdata_out
);
    initial
    begin
        {wr_out, rd_out, addr_out, wdata_out} = '0;
    end
    // Single access, never burst
    task automatic put(input logic w, input logic r,
        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        wr_out <= w;
        rd_out <= r;
        addr_out <= a;
        wdata_out <= d;
        @(posedge core_clk_in);
    endtask
    // k3 picks the bank of the command write
    task automatic entry(input logic [3:0] k, input logic [11:0] o2,
        input logic [3:0] k3);
        put(1'b1, 1'b0, {k, 9'h0, UNLOCK1_OFS}, {8'h0, UNLOCK1_DAT});
        put(1'b1, 1'b0, {k, 9'h0, o2}, {8'h0, UNLOCK2_DAT});
        put(1'b1, 1'b0, {k3, 9'h0, UNLOCK1_OFS}, {8'h0, IDENT_CMD});
        put(1'b0, 1'b0, '1, 16'hffff);
        put(1'b0, 1'b0, '0, '0);
    endtask
endmodule

// File: testbench/tb_flash_identify_mode.sv
// Bench for the identification-read block: entry, reads, exit, refusals.
// Host model drives the bus; the bench drives the array side.
`timescale 1ns/1ns
module tb_flash_identify_mode
    import fim_pkg::*;
;
    logic              clk, rst_n, wr, rd, busy, f_lk, c_lk;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, arr;
    logic [15:0]       susp, ident;
    logic [511:0]      lock;
    logic [3:0]        b;
    int                err_total = 0;
    int                compares = 0;
    logic [7:0] ofs [7] = '{8'h00, 8'h01, 8'h02, 8'h07, 8'h0e, 8'h0f, 8'h05};
    fim_top dut (.core_clk_in(clk), .rst_n_in(rst_n), .wr_in(wr), .rd_in(rd),
        .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata), .rvalid_out(),
        .array_data_in(arr), .busy_in(busy), .suspended_in(susp),
        .sector_lock_in(lock), .factory_lock_flag_in(f_lk),
        .customer_lock_flag_in(c_lk), .ident_banks_out(ident));
    fim_host_model hm (.core_clk_in(clk), .wr_out(wr), .rd_out(rd),
        .addr_out(addr), .wdata_out(wdata));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    function automatic logic [15:0] id_word(input logic [ADDR_W-1:0] a);
        case (a[7:0])
            MAKER_OFS: return MAKER_CODE;
            PART1_OFS: return PART_CODE1;
            LOCK_OFS:  return {15'h0, lock[a[24:16]]};
            INDIC_OFS: return {8'h0, f_lk, c_lk, 1'b0, WP_TOP_BOOT, 3'h0};
            PART2_OFS: return PART_CODE2;
            PART3_OFS: return PART_CODE3;
            default:   return ZERO_WORD;
        endcase
    endfunction
    // rdata holds until the next read, so it is sampled a cycle later
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic idm);
        hm.put(1'b0, 1'b1, a, ~wdata);
        hm.put(1'b0, 1'b0, ~a, wdata);
        chk(rdata, idm ? id_word(a) : arr);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        {rst_n, busy, f_lk, c_lk} = 4'h0;
        {susp, lock, arr} = {16'hffff, 512'h0, 16'h0};
        void'($urandom(7823));
        b = 4'($urandom);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        hm.entry(b, UNLOCK2_OFS, b);
        chk(ident, 16'h1 << b);
        for (int k = 0; k < 2; k++)
        begin
            lock <= {16{$urandom}};
            {f_lk, c_lk} <= {k[0], !k[0]};
            arr <= 16'($urandom);
            foreach (ofs[i])
                rd_chk({b, 13'($urandom), ofs[i]}, 1'b1);
            rd_chk({b + 4'h1, 21'($urandom)}, 1'b0);
        end
        hm.put(1'b1, 1'b0, 25'($urandom), {8'h0, RESET_CMD});
        repeat (2) hm.put(1'b0, 1'b0, '1, '0);
        chk(ident, 16'h0);
        rd_chk({b, 21'($urandom)}, 1'b0);
        busy <= 1'b1;
        hm.entry(b, UNLOCK2_OFS, b);
        chk(ident, 16'h0);
        busy <= 1'b0;
        hm.entry(b, UNLOCK2_OFS + 12'h1, b);
        chk(ident, 16'h0);
        hm.entry(b, UNLOCK2_OFS, b + 4'h1);
        chk(ident, 16'h0);
        tally_and_finish();
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end
endmodule
